// file: hdl/lpwm_top.sv
// led pwm generator: ahb-lite registers, clock source, three pwm channels
// and four general-purpose output ports
// assumes one ahb-lite master, single word transfers, ref_clk at 10 mhz
//
// Function
// - three channels, each with own 6-bit duty
// - high for (code+1)/64 of the period
// - no zero-duty code; minimum is 1/64
// - port value zero drives port constantly low
// - source bit: 0 internal oscillator, 1 pin
// - ratio bit: 0 for 300 khz, 1 for 38 khz
// - 38 khz external mode disables pwm output
// - ratio bit counts only in external mode
`timescale 1ns/1ps
`default_nettype none
`include "lpwm_defs.svh"

module lpwm_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // external clock pin
    input wire logic external_clock_pin,
    // general-purpose output ports
    output logic general_output_1,
    output logic general_output_2,
    output logic general_output_3,
    output logic general_output_4
);
    import lpwm_pkg::*;

    localparam logic [2:0] IDX_NONE = 3'h7;

    // ============================================================
    // address decode, shared by the read mux and the write path
    function automatic logic [2:0] reg_index(input logic [31:0] addr);
        logic [2:0] idx;
        idx = IDX_NONE;
        if (addr[31:8] == 24'h000000)
        begin
            case (addr[7:0])
                `LPWM_ADDR_DUTY1: idx = 3'h0;
                `LPWM_ADDR_DUTY2: idx = 3'h1;
                `LPWM_ADDR_DUTY3: idx = 3'h2;
                `LPWM_ADDR_CLKCFG: idx = 3'h3;
                `LPWM_ADDR_PORTCTL: idx = 3'h4;
                `LPWM_ADDR_STATUS: idx = 3'h5;
                default: idx = IDX_NONE;
            endcase
        end
        return idx;
    endfunction : reg_index

    // ============================================================
    // bus data phase tracking
    logic dp_wr_reg, dp_wr_next;
    logic [2:0] dp_idx_reg, dp_idx_next;
    logic [31:0] rdata_reg, rdata_next;
    logic addr_ok;

    // a transfer is taken when selected, nonseq or seq, and bus ready
    assign addr_ok = hsel & htrans[1] & hready;

    // ============================================================
    // software registers
    lpwm_duty_t duty_reg [3];
    lpwm_duty_t duty_next [3];
    lpwm_clk_cfg_s clk_cfg_reg, clk_cfg_next;
    lpwm_port_ctl_s port_ctl_reg, port_ctl_next;

    // ============================================================
    // block state seen by software and ports
    logic tick;
    logic pwm_enable;
    logic [2:0] pwm_level;
    logic [3:0] out_reg, out_next;
    logic [31:0] status_word;

    // ============================================================
    // register writes land in the data phase with hwdata
    always_comb
    begin
        duty_next = duty_reg;
        clk_cfg_next = clk_cfg_reg;
        port_ctl_next = port_ctl_reg;
        if (dp_wr_reg)
        begin
            case (dp_idx_reg)
                3'h0: duty_next[0] = hwdata[`LPWM_DUTY_W-1:0];
                3'h1: duty_next[1] = hwdata[`LPWM_DUTY_W-1:0];
                3'h2: duty_next[2] = hwdata[`LPWM_DUTY_W-1:0];
                3'h3:
                begin
                    clk_cfg_next.clock_source_select =
                        hwdata[`LPWM_CLK_SRC_BIT];
                    clk_cfg_next.external_clock_ratio =
                        hwdata[`LPWM_CLK_RATIO_BIT];
                end
                3'h4: port_ctl_next = hwdata[11:0];
                // status and unmapped addresses ignore writes
                default: port_ctl_next = port_ctl_reg;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            duty_reg[0] <= `LPWM_DUTY_RST;
            duty_reg[1] <= `LPWM_DUTY_RST;
            duty_reg[2] <= `LPWM_DUTY_RST;
            clk_cfg_reg <= 2'b00;
            port_ctl_reg <= `LPWM_PORTCTL_RST;
        end
        else
        begin
            duty_reg <= duty_next;
            clk_cfg_reg <= clk_cfg_next;
            port_ctl_reg <= port_ctl_next;
        end
    end

    // ============================================================
    // status word: live block state for software
    assign status_word = {20'h00000, 1'b0, pwm_level, out_reg,
        clk_cfg_reg.external_clock_ratio,
        clk_cfg_reg.clock_source_select, tick, pwm_enable};

    // ============================================================
    // address phase: capture the slot and prepare read data; the read
    // mux looks at next values so a write just ahead is forwarded
    always_comb
    begin
        dp_wr_next = addr_ok & hwrite;
        dp_idx_next = addr_ok ? reg_index(haddr) : IDX_NONE;
        rdata_next = rdata_reg;
        if (addr_ok && !hwrite)
        begin
            case (reg_index(haddr))
                3'h0: rdata_next = {26'h0000000, duty_next[0]};
                3'h1: rdata_next = {26'h0000000, duty_next[1]};
                3'h2: rdata_next = {26'h0000000, duty_next[2]};
                3'h3: rdata_next = {30'h00000000, clk_cfg_next};
                3'h4: rdata_next = {20'h00000, port_ctl_next};
                3'h5: rdata_next = status_word;
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            dp_wr_reg <= 1'b0;
            dp_idx_reg <= IDX_NONE;
            rdata_reg <= 32'h00000000;
        end
        else
        begin
            dp_wr_reg <= dp_wr_next;
            dp_idx_reg <= dp_idx_next;
            rdata_reg <= rdata_next;
        end
    end

    // zero wait states, always okay; hsize is not checked, words only
    assign hrdata = rdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ============================================================
    // fundamental clock and the three channels
    lpwm_tick_gen u_tick_gen (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_cfg(clk_cfg_reg),
        .external_clock_pin(external_clock_pin),
        .tick(tick),
        .pwm_enable(pwm_enable)
    );

    // each channel has its own counter and duty, fully independent
    for (genvar ch = 0; ch < 3; ch++)
    begin : g_ch
        lpwm_channel u_channel (
            .ref_clk(ref_clk),
            .rst(rst),
            .tick(tick),
            .pwm_enable(pwm_enable),
            .duty(duty_reg[ch]),
            .pwm_level(pwm_level[ch])
        );
    end

    // ============================================================
    // port drive: a zero value bit forces low whatever the mode
    always_comb
    begin
        for (int p = 0; p < 4; p++)
        begin
            case (lpwm_port_mode_e'(port_ctl_reg.mode[p]))
                LPWM_PORT_STATIC:
                    out_next[p] = port_ctl_reg.output_value[p];
                LPWM_PORT_CH1:
                    out_next[p] = port_ctl_reg.output_value[p] &
                        pwm_level[0];
                LPWM_PORT_CH2:
                    out_next[p] = port_ctl_reg.output_value[p] &
                        pwm_level[1];
                LPWM_PORT_CH3:
                    out_next[p] = port_ctl_reg.output_value[p] &
                        pwm_level[2];
                default: out_next[p] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            out_reg <= 4'h0;
        else
            out_reg <= out_next;
    end

    assign general_output_1 = out_reg[0];
    assign general_output_2 = out_reg[1];
    assign general_output_3 = out_reg[2];
    assign general_output_4 = out_reg[3];

    // ============================================================
    // checks
    port_low_a: assert property (@(posedge ref_clk) disable iff (rst)
        (port_ctl_reg.output_value == 4'h0) [*2] |-> (out_reg == 4'h0) [*2])
        else $error("port high while its value bit is zero");
    duty_indep_a: assert property (@(posedge ref_clk) disable iff (rst)
        (dp_wr_reg && dp_idx_reg == 3'h0) |=>
        (duty_reg[0] == $past(hwdata[5:0]) &&
        duty_reg[1] == $past(duty_reg[1]) &&
        duty_reg[2] == $past(duty_reg[2])))
        else $error("channel one write disturbed another channel");
    pwm_route_a: assert property (@(posedge ref_clk) disable iff (rst)
        (port_ctl_reg.mode[0] == 2'h1 && port_ctl_reg.output_value[0])
        |=> (out_reg[0] == $past(pwm_level[0])))
        else $error("port one does not follow channel one");
    read_back_a: assert property (@(posedge ref_clk) disable iff (rst)
        (addr_ok && !hwrite && reg_index(haddr) == 3'h3 && !dp_wr_reg)
        |=> (hrdata == {30'h00000000, clk_cfg_reg}))
        else $error("clock config read back wrong");
    cfg_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_cfg_reg == 2'b11) [*3] |-> (pwm_level == 3'h0) [*3])
        else $error("pwm running in 38 khz mode");

    // ============================================================
    // register write checks: each write lands in its slot, a duty write leaves the other duties alone; port four static level
    cfg_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        (dp_wr_reg && dp_idx_reg == 3'h3) |=>
        (clk_cfg_reg == $past(hwdata[1:0])))
        else $error("clock config write lost");
    duty_two_a: assert property (@(posedge ref_clk) disable iff (rst)
        (dp_wr_reg && dp_idx_reg == 3'h1) |=>
        (duty_reg[1] == $past(hwdata[5:0]) &&
        duty_reg[0] == $past(duty_reg[0]) &&
        duty_reg[2] == $past(duty_reg[2])))
        else $error("channel two write disturbed another");
    duty_three_a: assert property (@(posedge ref_clk) disable iff (rst)
        (dp_wr_reg && dp_idx_reg == 3'h2) |=>
        (duty_reg[2] == $past(hwdata[5:0]) &&
        duty_reg[0] == $past(duty_reg[0]) &&
        duty_reg[1] == $past(duty_reg[1])))
        else $error("channel three write disturbed another");
    port_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        (dp_wr_reg && dp_idx_reg == 3'h4) |=>
        (port_ctl_reg == $past(hwdata[11:0])))
        else $error("port control write lost");
    static_port_a: assert property (@(posedge ref_clk) disable iff (rst)
        (port_ctl_reg.mode[3] == 2'h0) |=>
        (out_reg[3] == $past(port_ctl_reg.output_value[3])))
        else $error("static port four lost its value");

    // ============================================================
    // bus checks: read data stands, read-only slots take no write
    rdata_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        !(addr_ok && !hwrite) |=> $stable(hrdata))
        else $error("read data changed without a read");
    no_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        (dp_wr_reg && dp_idx_reg > 3'h4) |=>
        ($stable(port_ctl_reg) && $stable(clk_cfg_reg) &&
        $stable(duty_reg[0])))
        else $error("read-only slot took a write");
    fwd_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        (addr_ok && !hwrite && reg_index(haddr) == 3'h0)
        |=> (hrdata == {26'h0000000, duty_reg[0]}))
        else $error("duty one read back wrong");
    // status shows live state; software polls it to see pwm is off
    // in the slow external mode
    status_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        (addr_ok && !hwrite && reg_index(haddr) == 3'h5)
        |=> (hrdata[0] == $past(pwm_enable) &&
        hrdata[3:2] == $past(clk_cfg_reg)))
        else $error("status word wrong");

    // ============================================================
    // per-port checks: a zero value bit keeps that one pin low,
    // and a channel-driven port follows its channel one cycle late
    for (genvar p = 0; p < 4; p++)
    begin : g_port_chk
        bit_low_a: assert property (
            @(posedge ref_clk) disable iff (rst)
            !port_ctl_reg.output_value[p] |=> !out_reg[p])
            else $error("port high while its value bit is zero");
        follow_a: assert property (
            @(posedge ref_clk) disable iff (rst)
            (port_ctl_reg.mode[p] != 2'h0 &&
            port_ctl_reg.output_value[p])
            |=> (out_reg[p] == $past(pwm_level[port_ctl_reg.mode[p] - 2'h1])))
            else $error("port does not follow its channel");
    end

    full_duty_c: cover property (@(posedge ref_clk) disable iff (rst)
        duty_reg[0] == 6'h3f && pwm_enable && tick);
    ext_mode_c: cover property (@(posedge ref_clk) disable iff (rst)
        clk_cfg_reg == 2'b01 && tick);
    slow_mode_c: cover property (@(posedge ref_clk) disable iff (rst)
        clk_cfg_reg == 2'b11);
    port_pwm_c: cover property (@(posedge ref_clk) disable iff (rst)
        out_reg[2] && port_ctl_reg.mode[2] == 2'h3);
    port_off_c: cover property (@(posedge ref_clk) disable iff (rst)
        !port_ctl_reg.output_value[0] && port_ctl_reg.mode[0] == 2'h1);

endmodule : lpwm_top
`default_nettype wire

// file: common/lpwm_defs.svh
// register map, field layout, reset values and timing counts of the led pwm
// block; included by the package and by every design file that needs them
`ifndef LPWM_DEFS_SVH
`define LPWM_DEFS_SVH

// ============================================================
// register byte addresses
`define LPWM_ADDR_DUTY1 8'h00
`define LPWM_ADDR_DUTY2 8'h04
`define LPWM_ADDR_DUTY3 8'h08
`define LPWM_ADDR_CLKCFG 8'h0c
`define LPWM_ADDR_PORTCTL 8'h10
`define LPWM_ADDR_STATUS 8'h14

// ============================================================
// field layout and reset values
`define LPWM_DUTY_W 6
`define LPWM_DUTY_RST 6'h00
`define LPWM_CLK_SRC_BIT 0
`define LPWM_CLK_RATIO_BIT 1
`define LPWM_PORT_VAL_LSB 0
`define LPWM_PORT_MODE_LSB 4
`define LPWM_PORTCTL_RST 12'h000
`define LPWM_STEP_LAST 6'h3f

// ============================================================
// timing: internal oscillator derived from the 10 mhz reference
`define LPWM_REF_CLK_KHZ 10000
`define LPWM_OSC_KHZ 300
`define LPWM_OSC_DIV ((`LPWM_REF_CLK_KHZ) / (`LPWM_OSC_KHZ))

`endif

// file: common/lpwm_pkg.sv
// types shared by the led pwm design files
// assumes lpwm_defs.svh is on the include path
`include "lpwm_defs.svh"

package lpwm_pkg;

    // ============================================================
    // port drive modes: static level or one of the three channels
    typedef enum logic [1:0] {
        LPWM_PORT_STATIC,
        LPWM_PORT_CH1,
        LPWM_PORT_CH2,
        LPWM_PORT_CH3
    } lpwm_port_mode_e;

    typedef logic [`LPWM_DUTY_W-1:0] lpwm_duty_t;

    // fundamental clock configuration
    typedef struct packed {
        logic external_clock_ratio;
        logic clock_source_select;
    } lpwm_clk_cfg_s;

    // port control: two mode bits per port above four output values
    typedef struct packed {
        logic [3:0][1:0] mode;
        logic [3:0] output_value;
    } lpwm_port_ctl_s;

endpackage : lpwm_pkg

// file: hdl/lpwm_tick_gen.sv
// fundamental clock selection: internal oscillator divider or the pin
// assumes external_clock_pin is synchronous to ref_clk and far slower
`timescale 1ns/1ps
`default_nettype none
`include "lpwm_defs.svh"

module lpwm_tick_gen (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // configuration
    input wire lpwm_pkg::lpwm_clk_cfg_s clk_cfg,
    // pin from the system
    input wire logic external_clock_pin,
    // fundamental clock step and pwm permission
    output logic tick,
    output logic pwm_enable
);
    import lpwm_pkg::*;

    localparam logic [5:0] OSC_LAST = 6'(`LPWM_OSC_DIV - 1);

    logic [5:0] osc_cnt_reg, osc_cnt_next;
    logic pin_reg, pin_next;
    logic tick_reg, tick_next;
    logic en_reg, en_next;
    logic osc_wrap, ext_rise;

    assign osc_wrap = (osc_cnt_reg == OSC_LAST);
    assign ext_rise = external_clock_pin & ~pin_reg;

    // ============================================================
    // source select; the ratio bit only counts in external mode
    always_comb
    begin
        osc_cnt_next = osc_wrap ? 6'h00 : osc_cnt_reg + 6'h01;
        pin_next = external_clock_pin;
        if (!clk_cfg.clock_source_select)
            tick_next = osc_wrap;
        else if (!clk_cfg.external_clock_ratio)
            tick_next = ext_rise;
        else
            tick_next = 1'b0;
        // 38 khz input is too slow for the step rate, so pwm is off
        en_next = ~(clk_cfg.clock_source_select &
            clk_cfg.external_clock_ratio);
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            osc_cnt_reg <= 6'h00;
            pin_reg <= 1'b0;
            tick_reg <= 1'b0;
            en_reg <= 1'b0;
        end
        else
        begin
            osc_cnt_reg <= osc_cnt_next;
            pin_reg <= pin_next;
            tick_reg <= tick_next;
            en_reg <= en_next;
        end
    end

    assign tick = tick_reg;
    assign pwm_enable = en_reg;

    // ============================================================
    // checks
    osc_tick_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!clk_cfg.clock_source_select && osc_wrap) |=> tick)
        else $error("oscillator wrap gave no tick");
    ext_tick_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_cfg == 2'b01) |=> (tick == $past(ext_rise)))
        else $error("tick does not follow the pin edge");
    ratio_ignore_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!clk_cfg.clock_source_select && clk_cfg.external_clock_ratio)
        |=> (tick == $past(osc_wrap)))
        else $error("ratio bit disturbed internal mode");
    pwm_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_cfg == 2'b11) |=> (!pwm_enable && !tick))
        else $error("pwm still enabled in 38 khz mode");

endmodule : lpwm_tick_gen
`default_nettype wire

// file: hdl/lpwm_channel.sv
// one pwm channel: 64-step counter and duty compare
// assumes tick is a one-cycle pulse from lpwm_tick_gen
`timescale 1ns/1ps
`default_nettype none
`include "lpwm_defs.svh"

module lpwm_channel (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // timing
    input wire logic tick,
    input wire logic pwm_enable,
    // setting
    input wire lpwm_pkg::lpwm_duty_t duty,
    // waveform
    output logic pwm_level
);
    import lpwm_pkg::*;

    logic [5:0] step_reg, step_next;
    lpwm_duty_t act_reg, act_next;
    logic lvl_reg, lvl_next;
    logic [6:0] hi_cnt_reg, hi_cnt_next;

    // ============================================================
    // duty is taken at period start so a write never makes a runt pulse
    always_comb
    begin
        step_next = step_reg;
        act_next = act_reg;
        if (!pwm_enable)
            step_next = 6'h00;
        else if (tick)
            step_next = step_reg + 6'h01;
        if (step_next == 6'h00)
            act_next = duty;
        // high from step zero through the code: (code+1)/64, never 0
        lvl_next = pwm_enable & (step_next <= act_next);
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            step_reg <= 6'h00;
            act_reg <= `LPWM_DUTY_RST;
            lvl_reg <= 1'b0;
        end
        else
        begin
            step_reg <= step_next;
            act_reg <= act_next;
            lvl_reg <= lvl_next;
        end
    end

    assign pwm_level = lvl_reg;

    // ============================================================
    // checks: helper counts high steps over one whole period
    always_comb
    begin
        hi_cnt_next = hi_cnt_reg;
        if (!pwm_enable)
            hi_cnt_next = 7'h00;
        else if (tick)
            hi_cnt_next = (step_reg == 6'h00) ? {6'h00, lvl_reg}
                : hi_cnt_reg + {6'h00, lvl_reg};
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            hi_cnt_reg <= 7'h00;
        else
            hi_cnt_reg <= hi_cnt_next;
    end

    duty_width_a: assert property (@(posedge ref_clk) disable iff (rst)
        (pwm_enable && tick && step_reg == `LPWM_STEP_LAST &&
        $past(pwm_enable, 1))
        |=> (hi_cnt_reg == {1'b0, $past(act_reg)} + 7'h01)
            || !$past(hi_cnt_reg[6:0] != 7'h00 || lvl_reg))
        else $error("high steps per period differ from code plus one");
    min_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
        (pwm_enable && $past(pwm_enable) && !$past(rst) &&
        step_reg == 6'h00) |-> pwm_level)
        else $error("no high pulse at step zero");
    idle_low_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!pwm_enable) [*2] |-> (!pwm_level) [*2])
        else $error("pwm level high while disabled");

endmodule : lpwm_channel
`default_nettype wire

// file: test/lpwm_ext_clk_model.sv
// system side of the clock pin: grounded in internal mode, else a clock
// assumes the bench sets the half period in reference clock cycles
`timescale 1ns/1ps
`default_nettype none

module lpwm_ext_clk_model (
    // clock
    input wire logic ref_clk,
    // control from the bench
    input wire logic ext_run,
    input wire logic [7:0] ext_half,
    // pin to the device
    output logic external_clock_pin
);
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic pin_reg;
    logic pin_next;

    // ============================================================
    // pin generator; kept synchronous so the device sees clean edges
    always_comb
    begin
        cnt_next = cnt_reg + 8'h01;
        pin_next = pin_reg;
        if (!ext_run)
        begin
            cnt_next = 8'h00;
            pin_next = 1'b0;
        end
        else if (cnt_reg + 8'h01 >= ext_half)
        begin
            cnt_next = 8'h00;
            pin_next = ~pin_reg;
        end
    end

    // register only
    always_ff @(posedge ref_clk)
    begin
        cnt_reg <= cnt_next;
        pin_reg <= pin_next;
    end

    assign external_clock_pin = pin_reg;
endmodule : lpwm_ext_clk_model
`default_nettype wire

// file: test/led_pwm_duty_and_clock_mode_bench.sv
// self-checking bench: registers over ahb-lite, clock modes, duty on ports
// assumes lpwm_defs.svh on the include path and a 10 mhz reference
`timescale 1ns/1ps
`default_nettype none
`include "lpwm_defs.svh"

module led_pwm_duty_and_clock_mode_bench;
    import lpwm_pkg::*;

    // ============================================================
    // signals and model state
    logic ref_clk;
    logic rst;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    wire logic [31:0] hrdata;
    wire logic hreadyout;
    wire logic hresp;
    wire logic ext_pin;
    wire logic [3:0] gp;
    logic ext_run;
    logic [7:0] ext_half;
    logic [31:0] rd_v;
    int error_cnt;
    int samples_checked;
    int hi_cnt [4];
    int code_m [3];
    int seed_v;

    lpwm_top dut_u (
        .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .external_clock_pin(ext_pin),
        .general_output_1(gp[0]), .general_output_2(gp[1]),
        .general_output_3(gp[2]), .general_output_4(gp[3])
    );

    lpwm_ext_clk_model src_u (
        .ref_clk(ref_clk), .ext_run(ext_run), .ext_half(ext_half),
        .external_clock_pin(ext_pin)
    );

    // ============================================================
    // clock and watchdog; the tests need about 40k cycles
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial
    begin
        repeat (60000) @(posedge ref_clk);
        error_cnt++;
        results();
    end

    // ============================================================
    // shared tasks
    task automatic results;
        if (error_cnt == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    // one single transfer; read data taken at the data phase edge
    task automatic ahb_xfer(input logic wr, input logic [31:0] a,
                            input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1)
            @(posedge ref_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1)
            @(posedge ref_clk);
        q = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask : ahb_xfer

    // configure, let two periods settle, count high cycles over one period
    task automatic run_case(input logic src, input logic ratio,
                            input logic [3:0] pval, input int unit);
        int len;
        int exp_v;
        logic [31:0] cfg;
        len = 64 * unit;
        cfg = {30'h0, ratio, src};
        ext_run <= src;
        ext_half <= 8'(unit / 2);
        for (int i = 0; i < 3; i++)
        begin
            ahb_xfer(1'b1, 32'(`LPWM_ADDR_DUTY1 + 4 * i), 32'(code_m[i]), rd_v);
            ahb_xfer(1'b0, 32'(`LPWM_ADDR_DUTY1 + 4 * i), 32'h0, rd_v);
            check(rd_v, 32'(code_m[i]));
        end
        ahb_xfer(1'b1, 32'(`LPWM_ADDR_CLKCFG), cfg, rd_v);
        ahb_xfer(1'b0, 32'(`LPWM_ADDR_CLKCFG), 32'h0, rd_v);
        check(rd_v, cfg);
        // ports 1..3 follow channels 1..3, port 4 stays static
        ahb_xfer(1'b1, 32'(`LPWM_ADDR_PORTCTL), {20'h0, 8'h39, pval}, rd_v);
        ahb_xfer(1'b0, 32'(`LPWM_ADDR_PORTCTL), 32'h0, rd_v);
        check(rd_v, {20'h0, 8'h39, pval});
        repeat (2 * len + 4) @(posedge ref_clk);
        hi_cnt = '{0, 0, 0, 0};
        repeat (len)
        begin
            @(posedge ref_clk);
            for (int i = 0; i < 4; i++)
                hi_cnt[i] += (gp[i] === 1'b1) ? 1 : 0;
        end
        for (int i = 0; i < 3; i++)
        begin
            exp_v = (pval[i] && !(src && ratio)) ? (code_m[i] + 1) * unit : 0;
            check(32'(hi_cnt[i]), 32'(exp_v));
        end
        check(32'(hi_cnt[3]), pval[3] ? 32'(len) : 32'h0);
    endtask : run_case

    // ============================================================
    // main sequence
    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        ext_run = 1'b0;
        ext_half = 8'h06;
        error_cnt = 0;
        samples_checked = 0;
        rst = 1'b1;
        seed_v = $urandom(92);
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        check({28'h0, gp}, 32'h0);
        ahb_xfer(1'b0, 32'(`LPWM_ADDR_DUTY1), 32'h0, rd_v);
        check(rd_v, 32'h0);
        // unmapped and upper-bit addresses read zero
        foreach (code_m[i])
        begin
            ahb_xfer(1'b1, (i == 0) ? 32'h18 : 32'h100, 32'hffff, rd_v);
            ahb_xfer(1'b0, (i == 0) ? 32'h18 : 32'h100, 32'h0, rd_v);
            check(rd_v, 32'h0);
        end
        code_m = '{63, 31, 0};
        run_case(1'b0, 1'b0, 4'hf, `LPWM_OSC_DIV);
        code_m = '{62, $urandom_range(61, 0), $urandom_range(63, 0)};
        run_case(1'b0, 1'b0, 4'b1010, `LPWM_OSC_DIV);
        code_m[0] = $urandom_range(63, 0);
        run_case(1'b0, 1'b1, 4'h7, `LPWM_OSC_DIV);
        run_case(1'b1, 1'b0, 4'hf, 12);
        run_case(1'b1, 1'b1, 4'hf, 94);
        // status is read only; pwm off, source and ratio set
        ahb_xfer(1'b1, 32'(`LPWM_ADDR_STATUS), 32'hffff, rd_v);
        ahb_xfer(1'b0, 32'(`LPWM_ADDR_STATUS), 32'h0, rd_v);
        check({28'h0, rd_v[3:0]}, 32'hc);
        results();
    end
endmodule : led_pwm_duty_and_clock_mode_bench
`default_nettype wire
